// ===== include/cfm_defs.svh
// Register indices, field positions, reset values of the fault mask bank.
// Assumes an APB slave with byte address = 4 * register index.
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH

// Register indices (byte address is four times the index)
`define CFM_IDX_HOST_TX 6'h0b
`define CFM_IDX_UPPER_CHAIN 6'h0c
`define CFM_IDX_UPPER_RC 6'h0d
`define CFM_IDX_UPPER_RR 6'h0e
`define CFM_IDX_IRQ_STATUS 6'h20
`define CFM_IDX_IRQ_MASK 6'h21

// Host transmit mask fields
`define CFM_HT_FRAME_START 1
`define CFM_HT_WAIT 0

// Upper chain mask fields
`define CFM_UC_BYTE_ERROR 5
`define CFM_UC_MISSING_DATA 4
`define CFM_UC_DATA_ORDER 3
`define CFM_UC_SECOND_SYNC 2
`define CFM_UC_FIRST_SYNC 1
`define CFM_UC_BIT_ERROR 0

// Upper receive-command mask fields (receive-response uses bits 4..0 alike)
`define CFM_RC_INTERNAL_ERROR 5
`define CFM_RC_TRANSMIT_DISABLED 4
`define CFM_RC_FRAME_START 3
`define CFM_RC_BYTE_ERROR 2
`define CFM_RC_UNEXPECTED_FRAME 1
`define CFM_RC_FRAME_CHECK 0

// Interrupt status bits, one per fault group
`define CFM_IRQ_HOST_TX 0
`define CFM_IRQ_UPPER_CHAIN 1
`define CFM_IRQ_UPPER_RC 2
`define CFM_IRQ_UPPER_RR 3

// Reset values
`define CFM_MASK_RST 8'h00
`define CFM_IRQ_RST 4'h0

`endif

// ===== include/cfm_pkg.sv
// Types shared by the fault mask bank and its bench.
// Assumes a 32-bit APB with 8-bit byte addresses.
package cfm_pkg;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } cfm_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } cfm_apb_rsp_t;

    // Fault flags, raw in and masked out
    typedef struct packed {
        logic [1:0] host_tx;
        logic [5:0] upper_chain;
        logic [5:0] upper_rc;
        logic [4:0] upper_rr;
    } cfm_faults_t;

    // Whole state of the bank
    typedef struct packed {
        logic [7:0] host_tx_mask;
        logic [7:0] upper_chain_mask;
        logic [7:0] upper_rc_mask;
        logic [7:0] upper_rr_mask;
        logic [3:0] irq_mask;
        logic [3:0] irq_status;
        cfm_apb_rsp_t rsp;
        cfm_faults_t flt_out;
        logic summary;
        logic irq;
    } cfm_state_t;

endpackage

// ===== verilog/cfm_regs.sv
// Communication fault mask register bank with APB access and interrupt.
// Assumes fault flags are synchronous to i_clk and the APB master
// follows the usual setup/access protocol.
`timescale 1ns/1ps
`include "cfm_defs.svh"

module cfm_regs (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire cfm_pkg::cfm_apb_req_t i_apb,
    input wire cfm_pkg::cfm_faults_t i_faults,
    output cfm_pkg::cfm_apb_rsp_t o_apb,
    output cfm_pkg::cfm_faults_t o_faults,
    output logic o_summary,
    output logic o_irq
);
    import cfm_pkg::*;

    cfm_state_t state_reg;
    cfm_state_t state_next;
    logic [5:0] idx;
    logic aligned;
    logic hit;
    logic acc_first;
    logic acc_done;
    logic [31:0] rd_word;
    logic [3:0] group_ev;
    cfm_faults_t pass;

    // Address decode; unaligned addresses count as unmapped
    assign idx = i_apb.paddr[7:2];
    assign aligned = (i_apb.paddr[1:0] == 2'h0);
    assign hit = aligned && (idx == `CFM_IDX_HOST_TX || idx == `CFM_IDX_UPPER_CHAIN
        || idx == `CFM_IDX_UPPER_RC || idx == `CFM_IDX_UPPER_RR
        || idx == `CFM_IDX_IRQ_STATUS || idx == `CFM_IDX_IRQ_MASK);

    // One wait state: answer prepared in first access cycle, given in the next
    assign acc_first = i_apb.psel && i_apb.penable && !state_reg.rsp.pready;
    assign acc_done = i_apb.psel && i_apb.penable && state_reg.rsp.pready;

    // masking, a 1 blocks and a 0 passes
    assign pass.host_tx = i_faults.host_tx & ~state_reg.host_tx_mask[1:0];
    assign pass.upper_chain = i_faults.upper_chain & ~state_reg.upper_chain_mask[5:0];
    assign pass.upper_rc = i_faults.upper_rc & ~state_reg.upper_rc_mask[5:0];
    assign pass.upper_rr = i_faults.upper_rr & ~state_reg.upper_rr_mask[4:0];

    // One interrupt event per fault group
    assign group_ev[`CFM_IRQ_HOST_TX] = |pass.host_tx;
    assign group_ev[`CFM_IRQ_UPPER_CHAIN] = |pass.upper_chain;
    assign group_ev[`CFM_IRQ_UPPER_RC] = |pass.upper_rc;
    assign group_ev[`CFM_IRQ_UPPER_RR] = |pass.upper_rr;

    // Read mux; spare bits read back as stored
    always_comb
    begin
        case (idx)
            `CFM_IDX_HOST_TX: rd_word = {24'h0, state_reg.host_tx_mask};
            `CFM_IDX_UPPER_CHAIN: rd_word = {24'h0, state_reg.upper_chain_mask};
            `CFM_IDX_UPPER_RC: rd_word = {24'h0, state_reg.upper_rc_mask};
            `CFM_IDX_UPPER_RR: rd_word = {24'h0, state_reg.upper_rr_mask};
            `CFM_IDX_IRQ_STATUS: rd_word = {28'h0, state_reg.irq_status};
            `CFM_IDX_IRQ_MASK: rd_word = {28'h0, state_reg.irq_mask};
            default: rd_word = 32'h0;
        endcase
    end

    // Next-state logic for the whole bank
    always_comb
    begin
        state_next = state_reg;

        // Bus answer: data and error are valid while pready is high
        state_next.rsp.pready = acc_first;
        state_next.rsp.prdata = 32'h0;
        state_next.rsp.pslverr = 1'b0;
        if (acc_first)
        begin
            state_next.rsp.pslverr = !hit;
            if (!i_apb.pwrite && hit)
            begin
                state_next.rsp.prdata = rd_word;
            end
        end

        // register writes, low byte lane only
        if (acc_done && i_apb.pwrite && hit && i_apb.pstrb[0])
        begin
            case (idx)
                `CFM_IDX_HOST_TX: state_next.host_tx_mask = i_apb.pwdata[7:0];
                `CFM_IDX_UPPER_CHAIN: state_next.upper_chain_mask = i_apb.pwdata[7:0];
                `CFM_IDX_UPPER_RC: state_next.upper_rc_mask = i_apb.pwdata[7:0];
                `CFM_IDX_UPPER_RR: state_next.upper_rr_mask = i_apb.pwdata[7:0];
                `CFM_IDX_IRQ_MASK: state_next.irq_mask = i_apb.pwdata[3:0];
                default: state_next.irq_mask = state_reg.irq_mask;
            endcase
        end

        // Read of status clears only the bits it reported; a new event wins
        if (acc_done && !i_apb.pwrite && aligned && idx == `CFM_IDX_IRQ_STATUS)
        begin
            state_next.irq_status = state_reg.irq_status & ~state_reg.rsp.prdata[3:0];
        end
        state_next.irq_status = state_next.irq_status | group_ev;

        // blocked faults never reach the summary
        state_next.flt_out = pass;
        state_next.summary = |pass;

        // Level interrupt from unmasked sticky status
        state_next.irq = |(state_reg.irq_status & state_reg.irq_mask);
    end

    // State register; synchronous reset to documented values
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_reg <= '0;
            state_reg.host_tx_mask <= `CFM_MASK_RST;
            state_reg.upper_chain_mask <= `CFM_MASK_RST;
            state_reg.upper_rc_mask <= `CFM_MASK_RST;
            state_reg.upper_rr_mask <= `CFM_MASK_RST;
            state_reg.irq_mask <= `CFM_IRQ_RST;
            state_reg.irq_status <= `CFM_IRQ_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_apb = state_reg.rsp;
    assign o_faults = state_reg.flt_out;
    assign o_summary = state_reg.summary;
    assign o_irq = state_reg.irq;

    // Written host mask reads back on the following cycle
    property p_host_wr;
        @(posedge i_clk) disable iff (i_srst)
        (acc_done && i_apb.pwrite && i_apb.pstrb[0] && aligned && idx == `CFM_IDX_HOST_TX)
        |=> (state_reg.host_tx_mask == $past(i_apb.pwdata[7:0]));
    endproperty
    a_host_wr: assert property (p_host_wr) else $error("host mask write lost");

    // Frame-start mask blocks the flag onward
    property p_host_sof;
        @(posedge i_clk) disable iff (i_srst)
        state_reg.host_tx_mask[`CFM_HT_FRAME_START] |=> !o_faults.host_tx[`CFM_HT_FRAME_START];
    endproperty
    a_host_sof: assert property (p_host_sof) else $error("masked SOF leaked");

    // Unmasked missing-data fault passes
    property p_chain_miss;
        @(posedge i_clk) disable iff (i_srst)
        (i_faults.upper_chain[`CFM_UC_MISSING_DATA]
            && !state_reg.upper_chain_mask[`CFM_UC_MISSING_DATA])
        |=> (o_faults.upper_chain[`CFM_UC_MISSING_DATA] && o_summary);
    endproperty
    a_chain_miss: assert property (p_chain_miss) else $error("missing-data lost");

    // Internal-error mask blocks its flag
    property p_rc_ierr;
        @(posedge i_clk) disable iff (i_srst)
        state_reg.upper_rc_mask[`CFM_RC_INTERNAL_ERROR]
        |=> !o_faults.upper_rc[`CFM_RC_INTERNAL_ERROR];
    endproperty
    a_rc_ierr: assert property (p_rc_ierr) else $error("masked ierr leaked");

    // Unmasked wait fault sets the host status bit; set wins over a clearing read
    property p_wait_pass;
        @(posedge i_clk) disable iff (i_srst)
        (i_faults.host_tx[`CFM_HT_WAIT] && !state_reg.host_tx_mask[`CFM_HT_WAIT])
        |=> state_reg.irq_status[`CFM_IRQ_HOST_TX];
    endproperty
    a_wait_pass: assert property (p_wait_pass) else $error("wait event lost");

    // Masks are zero right after reset
    property p_rst_zero;
        @(posedge i_clk)
        i_srst |=> (state_reg.host_tx_mask == 8'h00 && state_reg.upper_rr_mask == 8'h00
            && !o_summary && !o_irq);
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("reset value wrong");

    // Ready is a one-cycle pulse, so a held request is never taken on two cycles in a row
    property p_pready_pulse;
        @(posedge i_clk) disable iff (i_srst)
        o_apb.pready |=> !o_apb.pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held");

    // Host mask reads back with upper bits zero
    property p_rd_host;
        @(posedge i_clk) disable iff (i_srst)
        (acc_first && !i_apb.pwrite && aligned && idx == `CFM_IDX_HOST_TX)
        |=> (o_apb.prdata == {24'h0, $past(state_reg.host_tx_mask)});
    endproperty
    a_rd_host: assert property (p_rd_host) else $error("host mask read wrong");

    // Unmapped or unaligned access answers with an error
    property p_err_unmapped;
        @(posedge i_clk) disable iff (i_srst)
        (acc_first && !hit) |=> (o_apb.pready && o_apb.pslverr);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no error on miss");

    // A write without the low byte strobe leaves the mask alone
    property p_wr_strb;
        @(posedge i_clk) disable iff (i_srst)
        (acc_done && i_apb.pwrite && !i_apb.pstrb[0] && aligned && idx == `CFM_IDX_HOST_TX)
        |=> $stable(state_reg.host_tx_mask);
    endproperty
    a_wr_strb: assert property (p_wr_strb) else $error("unstrobed write landed");

    // Unmasked frame-start fault passes onward
    property p_host_sof_pass;
        @(posedge i_clk) disable iff (i_srst)
        (i_faults.host_tx[`CFM_HT_FRAME_START] && !state_reg.host_tx_mask[`CFM_HT_FRAME_START])
        |=> (o_faults.host_tx[`CFM_HT_FRAME_START] && o_summary);
    endproperty
    a_host_sof_pass: assert property (p_host_sof_pass) else $error("SOF lost");

    // Nothing unmasked means a quiet summary
    property p_summary_quiet;
        @(posedge i_clk) disable iff (i_srst)
        (pass == '0) |=> !o_summary;
    endproperty
    a_summary_quiet: assert property (p_summary_quiet) else $error("summary spurious");

    // Upper chain mask write reads back on the following cycle
    property p_chain_wr;
        @(posedge i_clk) disable iff (i_srst)
        (acc_done && i_apb.pwrite && i_apb.pstrb[0] && aligned && idx == `CFM_IDX_UPPER_CHAIN)
        |=> (state_reg.upper_chain_mask == $past(i_apb.pwdata[7:0]));
    endproperty
    a_chain_wr: assert property (p_chain_wr) else $error("chain mask write lost");

    // Byte-error mask of the chain blocks its flag
    property p_chain_byte;
        @(posedge i_clk) disable iff (i_srst)
        state_reg.upper_chain_mask[`CFM_UC_BYTE_ERROR]
        |=> !o_faults.upper_chain[`CFM_UC_BYTE_ERROR];
    endproperty
    a_chain_byte: assert property (p_chain_byte) else $error("masked byte leaked");

    // Unmasked first-sync fault passes
    property p_chain_sync1;
        @(posedge i_clk) disable iff (i_srst)
        (i_faults.upper_chain[`CFM_UC_FIRST_SYNC] && !state_reg.upper_chain_mask[`CFM_UC_FIRST_SYNC])
        |=> o_faults.upper_chain[`CFM_UC_FIRST_SYNC];
    endproperty
    a_chain_sync1: assert property (p_chain_sync1) else $error("sync1 lost");

    // Unmasked frame-check fault of receive-command passes
    property p_rc_crc;
        @(posedge i_clk) disable iff (i_srst)
        (i_faults.upper_rc[`CFM_RC_FRAME_CHECK] && !state_reg.upper_rc_mask[`CFM_RC_FRAME_CHECK])
        |=> o_faults.upper_rc[`CFM_RC_FRAME_CHECK];
    endproperty
    a_rc_crc: assert property (p_rc_crc) else $error("frame check lost");

    // Transmit-disabled mask blocks its flag
    property p_rc_txdis;
        @(posedge i_clk) disable iff (i_srst)
        state_reg.upper_rc_mask[`CFM_RC_TRANSMIT_DISABLED]
        |=> !o_faults.upper_rc[`CFM_RC_TRANSMIT_DISABLED];
    endproperty
    a_rc_txdis: assert property (p_rc_txdis) else $error("masked txdis leaked");

    // Wait mask blocks its flag
    property p_host_wait_block;
        @(posedge i_clk) disable iff (i_srst)
        state_reg.host_tx_mask[`CFM_HT_WAIT] |=> !o_faults.host_tx[`CFM_HT_WAIT];
    endproperty
    a_host_wait_block: assert property (p_host_wait_block) else $error("wait leaked");

    // Interrupt line follows unmasked sticky status one cycle later
    property p_irq_level;
        @(posedge i_clk) disable iff (i_srst)
        (|(state_reg.irq_status & state_reg.irq_mask)) |=> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq missing");

    // Full receive-response mask blocks every flag of the group
    property p_rr_block;
        @(posedge i_clk) disable iff (i_srst)
        (state_reg.upper_rr_mask[4:0] == 5'h1f) |=> (o_faults.upper_rr == 5'h00);
    endproperty
    a_rr_block: assert property (p_rr_block) else $error("rr mask leaked");

    // Unmasked start-of-frame fault of receive-response passes
    property p_rr_pass;
        @(posedge i_clk) disable iff (i_srst)
        (i_faults.upper_rr[`CFM_RC_FRAME_START] && !state_reg.upper_rr_mask[`CFM_RC_FRAME_START])
        |=> o_faults.upper_rr[`CFM_RC_FRAME_START];
    endproperty
    a_rr_pass: assert property (p_rr_pass) else $error("rr flag lost");

endmodule // cfm_regs

// ===== tb/cfm_regs_tb.sv
// Self-checking bench for the fault mask bank: APB access, masking, interrupt.
// Assumes the bank answers APB with one wait state and registers its outputs.
`timescale 1ns/1ps
`include "cfm_defs.svh"
`define CHK(got, want) check(64'(got), 64'(want))

module cfm_regs_tb;
    import cfm_pkg::*;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    cfm_apb_req_t i_apb = '0;
    cfm_faults_t i_faults = '0;
    cfm_apb_rsp_t o_apb;
    cfm_faults_t o_faults;
    logic o_summary;
    logic o_irq;
    int n_errors = 0;
    int compares = 0;
    logic [5:0] idx [4] = '{`CFM_IDX_HOST_TX, `CFM_IDX_UPPER_CHAIN, `CFM_IDX_UPPER_RC,
        `CFM_IDX_UPPER_RR};
    logic [7:0] msk [4];
    logic [31:0] rd;
    logic err;
    logic [3:0] strb = 4'hf;
    cfm_faults_t f;

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    cfm_regs dut (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_apb(i_apb),
        .i_faults(i_faults),
        .o_apb(o_apb),
        .o_faults(o_faults),
        .o_summary(o_summary),
        .o_irq(o_irq)
    );

    // Verdict and end of run, also reached by an exhausted wait
    task automatic conclude();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] want);
        compares++;
        if (got !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    // Expected onward flags: a set mask bit blocks, spares do nothing
    function automatic cfm_faults_t exp_flt(input cfm_faults_t x);
        exp_flt.host_tx = x.host_tx & ~msk[0][1:0];
        exp_flt.upper_chain = x.upper_chain & ~msk[1][5:0];
        exp_flt.upper_rc = x.upper_rc & ~msk[2][5:0];
        exp_flt.upper_rr = x.upper_rr & ~msk[3][4:0];
    endfunction

    // One APB transfer; waits for pready under a bound, data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
        output logic [31:0] rdat, output logic e);
        int n;
        @(posedge i_clk);
        i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd,
            pstrb: strb};
        @(posedge i_clk);
        i_apb.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end while (o_apb.pready !== 1'b1 && n < 20);
        rdat = o_apb.prdata;
        e = o_apb.pslverr;
        i_apb.psel <= 1'b0;
        i_apb.penable <= 1'b0;
        if (n >= 20)
        begin
            n_errors++;
            $display("unexpected at %0t: no pready", $time);
            conclude();
        end
    endtask

    initial
    begin
        void'($urandom(32'hb04c713f));
        repeat (12) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b0, {idx[r], 2'b00}, 32'h0, rd, err);
            `CHK({err, rd}, 33'h0);
        end
        // all ones, zeros, then random patterns
        for (int k = 0; k < 8; k++)
        begin
            for (int r = 0; r < 4; r++)
            begin
                msk[r] = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
                apb(1'b1, {idx[r], 2'b00}, {24'($urandom), msk[r]}, rd, err);
                apb(1'b0, {idx[r], 2'b00}, 32'h0, rd, err);
                `CHK({err, rd}, {25'h0, msk[r]});
            end
            // masked flags held back, flags pass otherwise
            f = cfm_faults_t'(19'($urandom));
            @(posedge i_clk);
            i_faults <= f;
            @(posedge i_clk);
            @(negedge i_clk);
            `CHK(o_faults, exp_flt(f));
            `CHK(o_summary, |exp_flt(f));
        end
        // Unmapped and unaligned addresses are refused
        apb(1'b0, 8'h40, 32'h0, rd, err);
        `CHK({err, rd}, {1'b1, 32'h0});
        apb(1'b0, 8'h2d, 32'h0, rd, err);
        `CHK(err, 1'b1);
        // Interrupt masked off: status sets but the line stays low
        @(posedge i_clk);
        i_faults <= '0;
        `CHK(o_irq, 1'b0);
        apb(1'b0, {`CFM_IDX_IRQ_STATUS, 2'b00}, 32'h0, rd, err);
        apb(1'b0, {`CFM_IDX_IRQ_STATUS, 2'b00}, 32'h0, rd, err);
        `CHK(rd, 32'h0);
        // Enable host group, unmask wait fault, pulse it
        apb(1'b1, {`CFM_IDX_IRQ_MASK, 2'b00}, 32'h1, rd, err);
        apb(1'b1, {idx[0], 2'b00}, 32'h0, rd, err);
        msk[0] = 8'h00;
        f = '0;
        f.host_tx = 2'b01;
        @(posedge i_clk);
        i_faults <= f;
        @(posedge i_clk);
        i_faults <= '0;
        repeat (2) @(negedge i_clk);
        `CHK(o_irq, 1'b1);
        // Read clears status and drops the line
        apb(1'b0, {`CFM_IDX_IRQ_STATUS, 2'b00}, 32'h0, rd, err);
        `CHK(rd, 32'h1);
        @(posedge i_clk);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0);
        // Write without the low byte strobe is ignored
        strb = 4'he;
        apb(1'b1, {idx[0], 2'b00}, 32'hff, rd, err);
        strb = 4'hf;
        apb(1'b0, {idx[0], 2'b00}, 32'h0, rd, err);
        `CHK({err, rd}, 33'h0);
        conclude();
    end
endmodule // cfm_regs_tb
